//--- rtl/dph_proc.sv
// Processor end: drives a data phase on the link clock.
// Assumes requests arrive on CLOCK_I; words cross by a toggle handshake.
`timescale 1ns/1ps
module dph_proc
	import dph_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic [CLK_W-1:0] WORD_I,
	input wire logic WORD_VALID_I,
	input wire logic WORD_LAST_I,
	output logic WORD_READY_O,
	output logic ORDER_N_A_O,
	dph_if.proc bus
);
	////////////////////////////////////////////////////////////////////////
	logic req_t_reg, ack_s1_reg, ack_s2_reg, ack_s3_reg, ack_seen_reg;
	logic l_ack_t_reg;
	logic [CLK_W-1:0] word_reg;
	logic last_reg;
	logic busy_reg;
	logic df_s1_reg, df_s2_reg, df_s3_reg, order_n_a_reg;
	wire ack_new = ack_s2_reg ^ ack_seen_reg;
	wire ack_agree = ack_s2_reg == ack_s3_reg;
	assign WORD_READY_O = !busy_reg;
	assign ORDER_N_A_O = order_n_a_reg;

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			req_t_reg <= 1'b0;
			busy_reg <= 1'b0;
			word_reg <= CLK_ZERO;
			last_reg <= 1'b0;
			{ack_s1_reg, ack_s2_reg, ack_s3_reg, ack_seen_reg} <= 4'h0;
			{df_s1_reg, df_s2_reg, df_s3_reg, order_n_a_reg} <= 4'h0;
		end else if (CE_I) begin
			ack_s1_reg <= l_ack_t_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
			df_s1_reg <= !bus.order_n_a;
			df_s2_reg <= df_s1_reg;
			df_s3_reg <= df_s2_reg;
			// Deferral sampled from the agent
			if (df_s2_reg == df_s3_reg)
				order_n_a_reg <= df_s2_reg;
			if (busy_reg && ack_new && ack_agree) begin
				ack_seen_reg <= ack_s2_reg;
				busy_reg <= 1'b0;
			end else if (!busy_reg && WORD_VALID_I) begin
				word_reg <= WORD_I;
				last_reg <= WORD_LAST_I;
				req_t_reg <= !req_t_reg;
				busy_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link side
	dph_state_t st_reg, st_next;
	logic rq_s1_reg, rq_s2_reg, rq_s3_reg, rq_seen_reg;
	logic l_busy_reg;
	logic own_reg;
	logic drop_reg;
	logic [63:0] d_reg;
	logic [3:0] inv_reg;
	logic valid_reg;
	wire l_rst_n = RST_N_I;
	wire rq_new = (rq_s2_reg ^ rq_seen_reg) && (rq_s2_reg == rq_s3_reg);
	wire bus_free = bus.data_bus_busy_n && l_busy_reg;
	logic [GRP_W*GRP_N+GRP_N-1:0] enc;

	always_comb begin
		enc = '0;
		for (int g = 0; g < GRP_N; g++)
			{enc[64+g], enc[g*GRP_W +: GRP_W]} =
				dph_encode(word_reg[g*GRP_W +: GRP_W]);
	end

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			DPH_IDLE: if (rq_new) st_next = own_reg ? DPH_SEND : DPH_WAIT;
			// Bus counted free only once busy was seen high
			DPH_WAIT: if (bus_free) st_next = DPH_SEND;
			DPH_SEND: st_next = DPH_IDLE;
			default: st_next = DPH_IDLE;
		endcase
	end

	always_ff @(posedge bus.link_clk or negedge l_rst_n) begin
		if (!l_rst_n) begin
			st_reg <= DPH_IDLE;
			{rq_s1_reg, rq_s2_reg, rq_s3_reg, rq_seen_reg} <= 4'h0;
			l_ack_t_reg <= 1'b0;
			l_busy_reg <= 1'b0;
			own_reg <= 1'b0;
			drop_reg <= 1'b0;
			d_reg <= 64'hFFFFFFFFFFFFFFFF;
			inv_reg <= 4'hF;
			valid_reg <= 1'b0;
		end else if (CE_I) begin
			rq_s1_reg <= req_t_reg;
			rq_s2_reg <= rq_s1_reg;
			rq_s3_reg <= rq_s2_reg;
			l_busy_reg <= bus.data_bus_busy_n;
			st_reg <= st_next;
			valid_reg <= 1'b0;
			// Release busy one clock after the last valid beat
			drop_reg <= 1'b0;
			if (drop_reg)
				own_reg <= 1'b0;
			if (st_reg == DPH_IDLE && rq_new)
				rq_seen_reg <= rq_s2_reg;
			if (st_next == DPH_SEND) begin
				own_reg <= 1'b1;
				d_reg <= enc[63:0];
				inv_reg <= enc[67:64];
				valid_reg <= 1'b1;
			end
			if (st_reg == DPH_SEND) begin
				l_ack_t_reg <= !l_ack_t_reg;
				// Hold busy through the last clock of the transfer
				if (last_reg)
					drop_reg <= 1'b1;
			end
		end
	end

	// One sub-phase per strobe edge is simplified to the low 64 bits of each word in one clock
	assign bus.drv_data_n = d_reg;
	assign bus.drv_inv_n = inv_reg;
	assign bus.drv_pstb_n = {GRP_N{!valid_reg}};
	assign bus.drv_nstb_n = {GRP_N{!valid_reg}};
	assign bus.drv_busy_n = !own_reg;
	assign bus.drv_valid_n = !valid_reg;
	assign bus.drv_oe = own_reg;
endmodule // dph_proc

//--- rtl/dph_pkg.sv
// Constants and types for the data-phase handshake of the front system bus.
// Assumes both ends share this package; the link runs on its own clock.
package dph_pkg;
	localparam int DATA_W = 64;
	localparam int GRP_W = 16;
	localparam int GRP_N = 4;
	localparam int SUB_N = 4;
	localparam int CLK_W = DATA_W * SUB_N;
	localparam int HALF_GRP = GRP_W / 2;
	localparam logic [1:0] SUB_LAST = 2'h3;
	localparam logic [CLK_W-1:0] CLK_ZERO = '0;

	typedef enum logic [2:0] {
		DPH_IDLE = 3'b001,
		DPH_WAIT = 3'b010,
		DPH_SEND = 3'b100
	} dph_state_t;

	// Count of ones in a group
	function automatic logic [4:0] dph_ones(input logic [GRP_W-1:0] v);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < GRP_W; i++)
			c = c + {4'h0, v[i]};
		return c;
	endfunction

	// Electrical group and its inversion flag for a logical group
	function automatic logic [GRP_W:0] dph_encode(input logic [GRP_W-1:0] v);
		logic inv;
		// Asserted-low bus: a logical one drives the wire low
		inv = dph_ones(v) > 5'(HALF_GRP);
		return inv ? {1'b0, v} : {1'b1, ~v};
	endfunction
endpackage

//--- rtl/dph_if.sv
// Shared wires of the front system bus data phase.
// Assumes a resolving bench: it ANDs the enabled low drivers.
`timescale 1ns/1ps
interface dph_if;
	logic link_clk;
	logic [63:0] data_n;
	logic [3:0] lane_invert_n;
	logic [3:0] pos_data_strobe_n;
	logic [3:0] neg_data_strobe_n;
	logic data_bus_busy_n;
	logic data_valid_n;
	logic order_n_a;
	logic [63:0] drv_data_n;
	logic [3:0] drv_inv_n;
	logic [3:0] drv_pstb_n;
	logic [3:0] drv_nstb_n;
	logic drv_busy_n;
	logic drv_valid_n;
	logic drv_oe;
	logic agt_busy_o;
	logic agt_busy_oe;
	logic agt_order_n_a_n;

	modport proc (input link_clk, data_n, lane_invert_n, pos_data_strobe_n,
		neg_data_strobe_n, data_bus_busy_n, data_valid_n, order_n_a,
		output drv_data_n, drv_inv_n, drv_pstb_n, drv_nstb_n, drv_busy_n,
		drv_valid_n, drv_oe);
	modport agent (input link_clk, data_n, lane_invert_n, pos_data_strobe_n,
		neg_data_strobe_n, data_bus_busy_n, data_valid_n,
		output agt_busy_o, agt_busy_oe, agt_order_n_a_n);
endinterface

//--- rtl/dph_agent.sv
// Agent end: receives data phases and raises deferral when ORDER_N_A_REQ_I is set.
// Assumes the processor end drives the bus; words cross by toggle.
`timescale 1ns/1ps
module dph_agent
	import dph_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic ORDER_N_A_REQ_I,
	output logic [DATA_W-1:0] WORD_O,
	output logic WORD_VALID_O,
	dph_if.agent bus
);
	////////////////////////////////////////////////////////////////////////
	logic [DATA_W-1:0] cap_reg;
	logic cap_t_reg;
	logic [DATA_W-1:0] rx;
	always_comb begin
		rx = '0;
		for (int g = 0; g < GRP_N; g++)
			rx[g*GRP_W +: GRP_W] = bus.lane_invert_n[g] ?
				~bus.data_n[g*GRP_W +: GRP_W] :
				bus.data_n[g*GRP_W +: GRP_W];
	end

	always_ff @(posedge bus.link_clk or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cap_reg <= '0;
			cap_t_reg <= 1'b0;
		end else if (CE_I && !bus.data_valid_n) begin
			cap_reg <= rx;
			cap_t_reg <= !cap_t_reg;
		end
	end

	assign bus.agt_busy_o = 1'b1;
	assign bus.agt_busy_oe = 1'b0;
	assign bus.agt_order_n_a_n = !ORDER_N_A_REQ_I;

	////////////////////////////////////////////////////////////////////////
	logic s1_reg, s2_reg, s3_reg, seen_reg, wv_reg;
	logic [DATA_W-1:0] wo_reg;
	wire hit = (s2_reg ^ seen_reg) && (s2_reg == s3_reg);
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			{s1_reg, s2_reg, s3_reg, seen_reg, wv_reg} <= 5'h00;
			wo_reg <= '0;
		end else if (CE_I) begin
			s1_reg <= cap_t_reg;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			wv_reg <= hit;
			if (hit) begin
				seen_reg <= s2_reg;
				wo_reg <= cap_reg;
			end
		end
	end
	assign WORD_O = wo_reg;
	assign WORD_VALID_O = wv_reg;
endmodule // dph_agent

//--- testbench/dph_assertions.sv
// Checker of the resolved data-phase wires of the shared bus.
// Assumes the interface signals are sampled on the link clock.
`timescale 1ns/1ps
module dph_assertions (
	input wire logic link_clk,
	input wire logic RST_N_I,
	input wire logic [63:0] data_n,
	input wire logic [3:0] lane_invert_n,
	input wire logic [3:0] pos_data_strobe_n,
	input wire logic [3:0] neg_data_strobe_n,
	input wire logic data_bus_busy_n,
	input wire logic data_valid_n,
	input wire logic drv_oe,
	input wire logic drv_busy_n
);
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!RST_N_I);
	////////////////////////////////////////////////////////////////////////
	sequence valid_beat;
		!data_valid_n ##1 (data_valid_n && !data_bus_busy_n);
	endsequence
	chk_beat_busy_hold: assert property ($fell(data_valid_n) |-> valid_beat)
		else $error("valid beat or busy hold wrong");
	chk_valid_busy: assert property (!data_valid_n |-> !data_bus_busy_n)
		else $error("valid without busy");
	chk_pos_strobe: assert property (pos_data_strobe_n == {4{data_valid_n}})
		else $error("positive strobe not with valid");
	chk_neg_strobe: assert property (neg_data_strobe_n == {4{data_valid_n}})
		else $error("negative strobe not with valid");
	chk_drive_owned: assert property (drv_oe |-> !drv_busy_n)
		else $error("driving without busy");
	chk_busy_release: assert property ($fell(data_bus_busy_n) |->
		##[1:1000] data_bus_busy_n)
		else $error("bus never released");
	for (genvar g = 0; g < 4; g++) begin : grp
		wire [15:0] w = data_n[16*g +: 16];
		chk_invert_heavy: assert property (!data_valid_n && !lane_invert_n[g] |-> $countones(w) > 8)
			else $error("inverted group not heavy");
		chk_plain_light: assert property (!data_valid_n && lane_invert_n[g] |-> $countones(w) >= 8)
			else $error("plain group too light");
	end
endmodule // dph_assertions

//--- testbench/testbench.sv
// Bench joining processor end and agent end over the data-phase wires.
// Assumes the bench resolves the shared wires from the drivers.
`timescale 1ns/1ps
module testbench;
	logic clk, lclk, rst_n, wvalid, wlast, order_n_a_req, ready, order_n_a_o, wv_o;
	logic [255:0] word;
	logic [63:0] w_o, seen_d;
	logic [3:0] seen_i;
	int miscompares = 0;
	int num_checks = 0;
	dph_if bus();
	assign bus.link_clk = lclk;
	assign bus.data_n = bus.drv_oe ? bus.drv_data_n : '1;
	assign bus.lane_invert_n = bus.drv_oe ? bus.drv_inv_n : '1;
	assign bus.pos_data_strobe_n = bus.drv_oe ? bus.drv_pstb_n : '1;
	assign bus.neg_data_strobe_n = bus.drv_oe ? bus.drv_nstb_n : '1;
	assign bus.data_valid_n = bus.drv_oe ? bus.drv_valid_n : 1'b1;
	assign bus.data_bus_busy_n = bus.drv_busy_n &
		(bus.agt_busy_oe ? bus.agt_busy_o : 1'b1);
	assign bus.order_n_a = bus.agt_order_n_a_n;
	dph_proc u_dph_proc (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
		.WORD_I(word), .WORD_VALID_I(wvalid), .WORD_LAST_I(wlast),
		.WORD_READY_O(ready), .ORDER_N_A_O(order_n_a_o), .bus(bus));
	dph_agent u_dph_agent (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
		.ORDER_N_A_REQ_I(order_n_a_req), .WORD_O(w_o), .WORD_VALID_O(wv_o), .bus(bus));
	dph_assertions u_dph_assertions (.link_clk(lclk), .RST_N_I(rst_n),
		.data_n(bus.data_n), .lane_invert_n(bus.lane_invert_n),
		.pos_data_strobe_n(bus.pos_data_strobe_n),
		.neg_data_strobe_n(bus.neg_data_strobe_n),
		.data_bus_busy_n(bus.data_bus_busy_n), .data_valid_n(bus.data_valid_n),
		.drv_oe(bus.drv_oe), .drv_busy_n(bus.drv_busy_n));
	initial begin clk = 0; forever #10 clk = ~clk; end
	initial begin lclk = 0; #3; forever #6 lclk = ~lclk; end
	// Capture the wire image of each valid beat
	always @(posedge lclk) if (!bus.data_valid_n) begin
		seen_d <= bus.data_n;
		seen_i <= bus.lane_invert_n;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [63:0] v, input logic last);
		logic [63:0] dec;
		logic [3:0] inv;
		int n;
		@(posedge clk);
		word <= {192'h0, v};
		wlast <= last;
		wvalid <= 1'b1;
		n = 0;
		@(negedge clk);
		while (ready !== 1'b1 && n < 200) begin @(negedge clk); n++; end
		@(posedge clk);
		wvalid <= 1'b0;
		n = 0;
		while (wv_o !== 1'b1 && n < 200) begin @(negedge clk); n++; end
		check(w_o, v);
		for (int g = 0; g < 4; g++) begin
			inv[g] = !($countones(v[16*g +: 16]) > 8);
			dec[16*g +: 16] = seen_i[g] ? ~seen_d[16*g +: 16] : seen_d[16*g +: 16];
		end
		check(seen_i, inv);
		check(dec, v);
		check(bus.data_bus_busy_n, last);
	endtask
	task automatic test_words();
		logic [63:0] tbl [4] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF,
			64'h01FF_00FF_FFFF_0000, 64'h1234_8001_FF7E_0F0F};
		for (int i = 0; i < 4; i++) send(tbl[i], i == 3);
		$display("test_words done");
	endtask
	task automatic test_order_n_a();
		@(posedge clk);
		order_n_a_req <= 1'b1;
		repeat (10) @(negedge clk);
		check(bus.order_n_a, 0);
		check(order_n_a_o, 1);
		@(posedge clk);
		order_n_a_req <= 1'b0;
		repeat (10) @(negedge clk);
		check(order_n_a_o, 0);
		$display("test_order_n_a done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		rst_n = 0; wvalid = 0; wlast = 0; word = '0; order_n_a_req = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		test_words();
		test_order_n_a();
		report_and_stop();
	end
	initial begin #100000; miscompares++; report_and_stop(); end
endmodule // testbench
